// *** pkg/sas_defs.svh ***
// Register offsets, field positions, reset values and timing counts for the converter sequencer
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// Register byte addresses
`define SAS_STATUS_CONTROL_OFS 12'h000
`define SAS_CONFIG_OFS 12'h004
`define SAS_PIN_ENABLE_OFS 12'h008
`define SAS_RESULT_HIGH_OFS 12'h00c
`define SAS_RESULT_LOW_OFS 12'h010
`define SAS_PRESCALE_OFS 12'h014

// Status and control fields
`define SAS_SC_CH_LSB 0
`define SAS_SC_CH_MSB 2
`define SAS_SC_REF_LSB 3
`define SAS_SC_REF_MSB 4
`define SAS_SC_IE_BIT 6
`define SAS_SC_CCF_BIT 7

// Config fields
`define SAS_CFG_PU_BIT 7

// Reset values
`define SAS_SC_RESET 8'h00
`define SAS_CFG_RESET 8'h00
`define SAS_PE_RESET 8'h00
`define SAS_PRESCALE_RESET 8'h00

// Sample window in conversion clock cycles
`define SAS_SAMPLE_CYCLES 5'd14
// Result width in bits and SAR bit steps
`define SAS_RESULT_BITS 10
`define SAS_SAR_STEPS 4'd10

`endif

// *** pkg/sas_pkg.sv ***
// Types shared by the converter sequencer
package sas_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    SAS_OFF,
    SAS_IDLE,
    SAS_SAMPLE,
    SAS_CONVERT,
    SAS_STORE
  } sas_state_e;

  // Source being converted
  typedef enum logic [1:0] {
    SAS_SRC_PIN,
    SAS_SRC_REF_LOW,
    SAS_SRC_REF_HIGH
  } sas_src_e;

endpackage

// *** src/sas_sequencer.sv ***
// Successive-approximation converter sequencer with APB register access
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`include "sas_defs.svh"

// Operation
// - Status-control write starts fresh conversion
// - Config write aborts, starts nothing
// - Pin-enable write aborts, starts nothing
// - Status-control write mid-conversion restarts conversion
// - Start commands sampler and SAR accept
// - Sample end tells SAR to convert
// - Conversion ends at SAR done, or early on abort, restart or power-up clear
// - Reference conversions skip sampling phase
// - Select channel, copy SAR to result
// - Result register is dual ported
// - Sampling and conversion never overlap
// - Sampler clocks gated when not sampling
// - Sample window is 14 conversion clocks
// - Exactly one of eight channels routed
// - Result delivered raw, no conditioning
// - Power-up clear aborts, enters low power
// - Complete flag clears on status-control write or result read
// - Interrupt at end with result ready
module sas_sequencer
  import sas_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_in,
  output logic [7:0] channel_select,
  output logic sample_enable,
  output logic sample_clock_enable,
  output logic sar_accept,
  output logic sar_convert,
  output logic [1:0] sar_reference_select,
  output logic [9:0] sar_dac_code,
  output logic analog_power_up,
  output logic completion_irq
);

  logic [7:0] adc_status_control_reg;
  logic [7:0] adc_config_reg;
  logic [7:0] adc_pin_enable_reg;
  logic [7:0] prescale;
  logic conversion_complete_flag;
  logic [9:0] result;
  logic [9:0] sar;
  logic [3:0] bit_step;
  logic [4:0] sample_count;
  logic [7:0] div_count;
  logic conversion_clock;
  logic cmp_meta;
  logic cmp_sync;
  sas_state_e state;
  sas_src_e src;

  logic wr_access;
  logic rd_access;
  logic wr_sc;
  logic wr_abort;
  logic rd_result;
  logic done;
  logic converter_power_up;

  // Address match on a completed APB access
  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    hit = (a == ofs);
  endfunction

  // Reference field to source kind
  function automatic sas_src_e ref_src(input logic [1:0] r);
    case (r)
      2'h1: ref_src = SAS_SRC_REF_LOW;
      2'h2: ref_src = SAS_SRC_REF_HIGH;
      default: ref_src = SAS_SRC_PIN;
    endcase
  endfunction

  // Zero-wait slave, every access completes in its access phase
  assign pready = 1'b1;
  assign wr_access = psel & penable & pwrite;
  assign rd_access = psel & penable & ~pwrite;
  assign wr_sc = wr_access & hit(paddr, `SAS_STATUS_CONTROL_OFS);
  assign wr_abort = wr_access & (hit(paddr, `SAS_CONFIG_OFS)
                    | hit(paddr, `SAS_PIN_ENABLE_OFS));
  assign rd_result = rd_access & (hit(paddr, `SAS_RESULT_HIGH_OFS)
                     | hit(paddr, `SAS_RESULT_LOW_OFS));
  assign converter_power_up = adc_config_reg[`SAS_CFG_PU_BIT];
  assign analog_power_up = converter_power_up;
  assign done = (state == SAS_CONVERT) && conversion_clock && (bit_step == 4'd0);

  // Unmapped addresses answer with an error
  always_comb begin
    pslverr = psel & penable & ~(hit(paddr, `SAS_STATUS_CONTROL_OFS)
              | hit(paddr, `SAS_CONFIG_OFS) | hit(paddr, `SAS_PIN_ENABLE_OFS)
              | hit(paddr, `SAS_RESULT_HIGH_OFS) | hit(paddr, `SAS_RESULT_LOW_OFS)
              | hit(paddr, `SAS_PRESCALE_OFS));
  end

  // Software-written registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_status_control_reg <= `SAS_SC_RESET;
      adc_config_reg <= `SAS_CFG_RESET;
      adc_pin_enable_reg <= `SAS_PE_RESET;
      prescale <= `SAS_PRESCALE_RESET;
    end else if (wr_access) begin
      if (hit(paddr, `SAS_STATUS_CONTROL_OFS)) begin
        adc_status_control_reg <= {1'b0, pwdata[6:0]}; // Flag bit is read-only
      end
      if (hit(paddr, `SAS_CONFIG_OFS)) begin
        adc_config_reg <= pwdata[7:0];
      end
      if (hit(paddr, `SAS_PIN_ENABLE_OFS)) begin
        adc_pin_enable_reg <= pwdata[7:0];
      end
      if (hit(paddr, `SAS_PRESCALE_OFS)) begin
        prescale <= pwdata[7:0];
      end
    end
  end

  // Registered read data; reads sample the dual-ported result independently
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= 32'h0;
      case (paddr)
        `SAS_STATUS_CONTROL_OFS: prdata[7:0] <= {conversion_complete_flag,
                                                 adc_status_control_reg[6:0]};
        `SAS_CONFIG_OFS: prdata[7:0] <= adc_config_reg;
        `SAS_PIN_ENABLE_OFS: prdata[7:0] <= adc_pin_enable_reg;
        `SAS_RESULT_HIGH_OFS: prdata[7:0] <= {6'h00, result[9:8]};
        `SAS_RESULT_LOW_OFS: prdata[7:0] <= result[7:0];
        `SAS_PRESCALE_OFS: prdata[7:0] <= prescale;
        default: prdata <= 32'h0;
      endcase
    end
  end

  // Conversion clock enable from the prescaler; stopped while powered down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_count <= 8'h00;
      conversion_clock <= 1'b0;
    end else if (!converter_power_up) begin
      div_count <= 8'h00;
      conversion_clock <= 1'b0;
    end else if (wr_sc) begin
      // Restart phase on each start so the window is whole and the synced comparator settles
      div_count <= 8'h00;
      conversion_clock <= 1'b0;
    end else if (div_count >= prescale) begin
      div_count <= 8'h00;
      conversion_clock <= 1'b1;
    end else begin
      div_count <= div_count + 8'h01;
      conversion_clock <= 1'b0;
    end
  end

  // Comparator is analog, so it is synchronised first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta <= 1'b0;
      cmp_sync <= 1'b0;
    end else begin
      cmp_meta <= comparator_in;
      cmp_sync <= cmp_meta;
    end
  end

  // Mode control state machine; power-down beats everything, other aborts beat everything but a restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= SAS_OFF;
      src <= SAS_SRC_PIN;
      sample_count <= 5'd0;
      bit_step <= 4'd0;
      sar <= 10'h000;
    end else if (!converter_power_up) begin
      state <= SAS_OFF;
      sar <= 10'h000;
    end else if (wr_sc) begin
      // New conversion, abandoning any in flight
      src <= ref_src(pwdata[`SAS_SC_REF_MSB:`SAS_SC_REF_LSB]);
      sar <= 10'h200;
      bit_step <= `SAS_SAR_STEPS;
      sample_count <= 5'd0;
      if (ref_src(pwdata[`SAS_SC_REF_MSB:`SAS_SC_REF_LSB]) == SAS_SRC_PIN) begin
        state <= SAS_SAMPLE;
      end else begin
        state <= SAS_CONVERT;
      end
    end else if (wr_abort) begin
      state <= SAS_IDLE;
      sar <= 10'h000;
    end else begin
      case (state)
        SAS_OFF: begin
          state <= SAS_IDLE;
        end
        SAS_IDLE: begin
          state <= SAS_IDLE;
        end
        SAS_SAMPLE: begin
          if (conversion_clock) begin
            if (sample_count == `SAS_SAMPLE_CYCLES - 5'd1) begin
              state <= SAS_CONVERT;
            end
            sample_count <= sample_count + 5'd1;
          end
        end
        SAS_CONVERT: begin
          // One bit decided per conversion clock, MSB first
          if (conversion_clock && bit_step != 4'd0) begin
            bit_step <= bit_step - 4'd1;
            if (!cmp_sync) begin
              sar[bit_step - 4'd1] <= 1'b0;
            end
            if (bit_step > 4'd1) begin
              sar[bit_step - 4'd2] <= 1'b1;
            end
          end
          if (done) begin
            state <= SAS_STORE;
          end
        end
        SAS_STORE: begin
          state <= SAS_IDLE;
        end
        default: state <= SAS_IDLE;
      endcase
    end
  end

  // Result write port and completion flag; hardware set wins over a result-read clear, a status-control write wins over set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result <= 10'h000;
      conversion_complete_flag <= 1'b0;
    end else if (state == SAS_STORE && !wr_sc && !wr_abort && converter_power_up) begin
      result <= sar;
      conversion_complete_flag <= 1'b1;
    end else if (wr_sc || rd_result) begin
      conversion_complete_flag <= 1'b0;
    end
  end

  // Analog-side controls derived from state
  always_comb begin
    channel_select = 8'h00;
    if (src == SAS_SRC_PIN && (state == SAS_SAMPLE)) begin
      channel_select[adc_status_control_reg[`SAS_SC_CH_MSB:`SAS_SC_CH_LSB]] = 1'b1;
    end
  end
  assign sample_enable = (state == SAS_SAMPLE);
  assign sample_clock_enable = (state == SAS_SAMPLE) & conversion_clock;
  assign sar_accept = (state == SAS_SAMPLE);
  assign sar_convert = (state == SAS_CONVERT);
  assign sar_reference_select = src;
  assign sar_dac_code = sar;
  assign completion_irq = conversion_complete_flag
                          & adc_status_control_reg[`SAS_SC_IE_BIT];

endmodule

// *** verif/sas_sequencer_assertions.sv ***
// Port-level assertions for the converter sequencer
`timescale 1ns/100ps
module sas_sequencer_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [7:0] channel_select,
  input wire logic sample_enable,
  input wire logic sample_clock_enable,
  input wire logic sar_accept,
  input wire logic sar_convert,
  input wire logic [1:0] sar_reference_select,
  input wire logic analog_power_up,
  input wire logic completion_irq
);
  logic [4:0] win_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Sampler pulses in the current window, cleared between windows and on a restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) win_cnt <= 5'h00;
    else if (!sample_enable) win_cnt <= 5'h00;
    else if (psel && penable && pwrite && paddr == 12'h000) win_cnt <= 5'h00;
    else if (sample_clock_enable) win_cnt <= win_cnt + 5'h01;
  end
  sequence s_window_done;
    $fell(sample_enable) && sar_convert;
  endsequence
  a_no_overlap: assert property (!(sample_enable && sar_convert))
    else $error("sampling and conversion overlap");
  a_accept_tracks: assert property (sar_accept == sample_enable)
    else $error("accept differs from sample enable");
  a_clock_gated: assert property (!sample_enable |-> !sample_clock_enable)
    else $error("sampler clock runs outside window");
  a_one_channel: assert property (sample_enable && sar_reference_select == 2'h0
    |-> $onehot(channel_select)) else $error("channel select not one-hot");
  a_channel_idle: assert property (!sample_enable |-> channel_select == 8'h00)
    else $error("channel routed outside window");
  a_window_len: assert property (s_window_done |-> win_cnt == 5'h0e)
    else $error("sample window length wrong");
  a_convert_cause: assert property ($rose(sar_convert) |->
    $past(sample_enable) || sar_reference_select != 2'h0) else $error("convert without sample");
  a_power_gate: assert property (!analog_power_up |-> !sample_enable && !sar_convert)
    else $error("activity while powered down");
  a_irq_quiet: assert property (completion_irq |-> !sample_enable && !sar_convert)
    else $error("flag held during conversion");
endmodule

// *** verif/sas_analog_model.sv ***
// Analog sources and comparator for the converter sequencer
`timescale 1ns/100ps
module sas_analog_model (
  input wire logic pclk,
  input wire logic [7:0] channel_select,
  input wire logic sample_enable,
  input wire logic [1:0] sar_reference_select,
  input wire logic [9:0] sar_dac_code,
  output logic comparator_in
);
  logic [9:0] held = 10'h155;
  // Charge follows the routed pin only while sampling
  always @(posedge pclk) begin
    for (int i = 0; i < 8; i++) begin
      if (sample_enable && channel_select[i]) held <= {i[2:0], 7'h5a};
    end
  end
  // References never pass the sampler, level set inside SAR
  assign comparator_in = sar_reference_select == 2'h1 ? 1'b0 :
    sar_reference_select == 2'h2 ? 1'b1 : held >= sar_dac_code;
endmodule

// *** verif/sas_sequencer_tb.sv ***
// Self-checking bench for the converter sequencer
`timescale 1ns/100ps
module sas_sequencer_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, comparator_in, sample_enable, sample_clock_enable;
  logic sar_accept, sar_convert, analog_power_up, completion_irq;
  logic [7:0] channel_select;
  logic [1:0] sar_reference_select;
  logic [9:0] sar_dac_code;
  int errors = 0, num_checks = 0, cyc = 0, pulses = 0;
  sas_sequencer uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .comparator_in, .channel_select, .sample_enable, .sample_clock_enable,
    .sar_accept, .sar_convert, .sar_reference_select, .sar_dac_code, .analog_power_up,
    .completion_irq);
  sas_analog_model far (.pclk, .channel_select, .sample_enable, .sar_reference_select,
    .sar_dac_code, .comparator_in);
  initial forever #20 pclk = ~pclk;
  // Hang guard and sampler pulse count
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (sample_enable === 1'b1 && sample_clock_enable === 1'b1) pulses <= pulses + 1;
    if (cyc == 40000) begin
      errors++;
      results;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Setup, then hold access until pready; one idle cycle after
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic convert(input logic [7:0] sc);
    apb(1'b1, 12'h000, {24'h0, sc});
    pulses = 0; // Old window pulses are all counted by now
    repeat (1500) begin
      @(posedge pclk);
      if (completion_irq === 1'b1) break;
    end
  endtask
  task automatic t_reset;
    check(analog_power_up, 0);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 0);
    apb(1'b0, 12'h018, 32'h0);
    check(err, 1);
    check(rd, 0);
  endtask
  // Prescale 12 keeps conversion clock near 1.92 MHz
  task automatic t_channels;
    apb(1'b1, 12'h004, 32'h80);
    apb(1'b1, 12'h014, 32'hc);
    for (int c = 0; c < 8; c++) begin
      convert(8'h40 | c[7:0]);
      check({completion_irq, 5'(pulses)}, {1'b1, 5'h0e});
      apb(1'b0, 12'h00c, 32'h0);
      check(rd, c[2:1]);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, {c[0], 7'h5a});
      check(completion_irq, 0);
    end
  endtask
  task automatic t_refs;
    for (int r = 1; r < 3; r++) begin
      convert(8'h40 | 8'(r << 3));
      check({completion_irq, 5'(pulses)}, {1'b1, 5'h00});
      apb(1'b0, 12'h010, 32'h0);
      check(rd, r == 2 ? 32'hff : 32'h0);
    end
  endtask
  // Aborts in sample, in convert, then by power down
  task automatic t_abort;
    logic [11:0] aa[3] = '{12'h004, 12'h008, 12'h004};
    logic [7:0] dd[3] = '{8'h80, 8'h00, 8'h00};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, 12'h000, 32'h43);
      repeat (100 + 90 * i) @(posedge pclk);
      apb(1'b1, aa[i], {24'h0, dd[i]});
      repeat (800) @(posedge pclk);
      apb(1'b0, 12'h000, 32'h0);
      check({completion_irq, rd[7]}, 0);
    end
    check(analog_power_up, 0);
    apb(1'b1, 12'h004, 32'h80);
  endtask
  // Restart while converting, then while sampling
  task automatic t_restart;
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, 12'h000, 32'h41);
      repeat (250 - 190 * k) @(posedge pclk);
      convert(8'h45);
      check(5'(pulses), 5'h0e);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, {1'b1, 7'h5a});
    end
  endtask
  task automatic results;
    $display("Errors %0d, checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_channels;
    t_refs;
    t_abort;
    t_restart;
    results;
  end
endmodule
bind sas_sequencer sas_sequencer_assertions chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .channel_select,
  .sample_enable, .sample_clock_enable, .sar_accept, .sar_convert, .sar_reference_select,
  .analog_power_up, .completion_irq);
